// ---- hw/mhc_cfg.sv ----
`timescale 1ns/1ns
module mhc_cfg
  import mhc_pkg::*;
(
  input  wire logic                clock,
  input  wire logic                rst_n,
  input  wire logic                ce,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                master_wr,
  input  wire logic                master_rd,
  input  wire logic                slave_wr,
  input  wire logic                slave_rd,
  input  wire logic [3:0]          mbx_index,
  output logic [NUM_HS*SEL_W-1:0]  hs_select,
  output logic [NUM_HS-1:0]        hs_active,
  output logic [NUM_HS-1:0]        hs_ready,
  output logic [NUM_MBX-1:0]       mailbox_direction_fuse,
  output logic [PA_PINS-1:0]       port_a_pin_owner,
  output logic [PB_PINS-1:0]       port_b_pin_owner
);
  // Non-volatile array survives reset; only programming changes it
  logic [CFG_W-1:0] nvm_r [NUM_WORDS] = '{default: CFG_ERASED};
  logic [CFG_W-1:0] nvm_nxt [NUM_WORDS];
  logic [NUM_WORDS-1:0] used_r, used_nxt;
  logic             key_r, key_nxt;
  logic [31:0]      prdata_nxt;
  logic             pready_nxt, pslverr_nxt;
  logic [NUM_HS*SEL_W-1:0] sel_nxt;
  logic [NUM_HS-1:0] act_nxt;
  logic [NUM_MBX-1:0] dir_nxt;
  logic [PA_PINS-1:0] pa_nxt;
  logic [PB_PINS-1:0] pb_nxt;
  logic             acc;
  logic [2:0]       widx;
  logic             wvalid;
  logic [23:0]      wmask;

  assign acc = psel && penable && pready;

  always_comb begin
    widx   = WI_ASSIGN_LO;
    wvalid = 1'b1;
    wmask  = MASK_16;
    if (paddr == OFS_ASSIGN_LO) begin
      widx = WI_ASSIGN_LO;
    end else if (paddr == OFS_ASSIGN_HI) begin
      widx = WI_ASSIGN_HI;
    end else if (paddr == OFS_HS_EN) begin
      widx  = WI_HS_EN;
      wmask = MASK_EN;
    end else if (paddr == OFS_PORT_A) begin
      widx  = WI_PORT_A;
      wmask = MASK_PA;
    end else if (paddr == OFS_PORT_B) begin
      widx = WI_PORT_B;
    end else if (paddr == OFS_DIR) begin
      widx = WI_DIR;
    end else begin
      wvalid = 1'b0;
    end
  end

  // Programming: once per word between resets, only after the key; bits can only clear
  always_comb begin
    for (int i = 0; i < NUM_WORDS; i++) nvm_nxt[i] = nvm_r[i];
    used_nxt    = used_r;
    key_nxt     = key_r;
    prdata_nxt  = 32'h00000000;
    pslverr_nxt = 1'b0;
    pready_nxt  = 1'b0;
    // Answer one cycle into the access phase; refusal is decided then
    if (psel && penable && !pready) begin
      pready_nxt = 1'b1;
      if (pwrite) begin
        if (paddr != OFS_PROG_KEY
            && !(wvalid && key_r && !used_r[widx])) begin
          pslverr_nxt = 1'b1;
        end
      end else if (wvalid) begin
        prdata_nxt = {8'h00, nvm_r[widx] | ~wmask};
      end else if (paddr == OFS_STATUS) begin
        prdata_nxt = {23'h000000, key_r, 2'h0, used_r};
      end else begin
        pslverr_nxt = 1'b1;
      end
    end
    // A write lands only at the edge that completes the transfer
    if (acc && pwrite && !pslverr) begin
      if (paddr == OFS_PROG_KEY) begin
        key_nxt = (pwdata == PROG_KEY_VAL);
      end else begin
        nvm_nxt[widx] = nvm_r[widx] & (pwdata[23:0] | ~wmask);
        used_nxt[widx] = 1'b1;
        key_nxt = 1'b0;
      end
    end
  end

  // Decoded outputs track the array; an erased array gives all ones, except hs_active, which is inverted to all zeros
  always_comb begin
    sel_nxt = {nvm_r[WI_ASSIGN_HI][15:0], nvm_r[WI_ASSIGN_LO][15:0]};
    act_nxt = ~nvm_r[WI_HS_EN][NUM_HS-1:0];
    dir_nxt = nvm_r[WI_DIR][NUM_MBX-1:0];
    pa_nxt  = nvm_r[WI_PORT_A][PA_PINS-1:0];
    pb_nxt  = nvm_r[WI_PORT_B][PB_PINS-1:0];
  end

  always_ff @(posedge clock) begin
    if (ce) begin
      for (int i = 0; i < NUM_WORDS; i++) nvm_r[i] <= nvm_nxt[i];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      used_r                 <= '0;
      key_r                  <= 1'b0;
      prdata                 <= 32'h00000000;
      pready                 <= 1'b0;
      pslverr                <= 1'b0;
      hs_select              <= '1;
      hs_active              <= '0;
      mailbox_direction_fuse <= '1;
      port_a_pin_owner       <= '1;
      port_b_pin_owner       <= '1;
    end else if (ce) begin
      used_r                 <= used_nxt;
      key_r                  <= key_nxt;
      prdata                 <= prdata_nxt;
      pready                 <= pready_nxt;
      pslverr                <= pslverr_nxt;
      hs_select              <= sel_nxt;
      hs_active              <= act_nxt;
      mailbox_direction_fuse <= dir_nxt;
      port_a_pin_owner       <= pa_nxt;
      port_b_pin_owner       <= pb_nxt;
    end
  end

  // Handshake flag per block; direction picks which core sends
  for (genvar g = 0; g < NUM_HS; g++) begin : g_hs
    logic hit, dir, snd, rcv;
    assign hit = (mbx_index == hs_select[g*SEL_W +: SEL_W]);
    assign dir = mailbox_direction_fuse[mbx_index];
    assign snd = hit && (dir ? slave_wr : master_wr);
    assign rcv = hit && (dir ? master_rd : slave_rd);
    mhc_hs_flag u_flag (
      .clock   (clock),
      .rst_n   (rst_n),
      .ce      (ce),
      .active  (hs_active[g]),
      .snd_wr  (snd),
      .rcv_rd  (rcv),
      .ready_r (hs_ready[g])
    );
  end

  sequence s_sent(int k);
    hs_active[k] && mbx_index == hs_select[k*SEL_W +: SEL_W]
      && !mailbox_direction_fuse[mbx_index] && master_wr;
  endsequence

  sequence s_read(int k);
    hs_active[k] && mbx_index == hs_select[k*SEL_W +: SEL_W]
      && (mailbox_direction_fuse[mbx_index] ? master_rd : slave_rd);
  endsequence

  hs_clr_a: assert property (@(posedge clock) disable iff (!rst_n)
    ce && !master_wr && !slave_wr ##0 s_read(0) |=> !hs_ready[0])
    else $error("ready not cleared after read");
  kl_refuse_a: assert property (@(posedge clock) disable iff (!rst_n)
    pready && pwrite && !key_r && paddr != OFS_PROG_KEY |-> pslverr)
    else $error("keyless write not refused");

  hs_set_a: assert property (@(posedge clock) disable iff (!rst_n)
    ce ##0 s_sent(0) |=> hs_ready[0])
    else $error("ready not raised after send");
  hs_off_a: assert property (@(posedge clock) disable iff (!rst_n)
    ce && !hs_active[1] |=> !hs_ready[1])
    else $error("disabled block shows ready");
  ro_one_a: assert property (@(posedge clock) disable iff (!rst_n)
    pready && !pwrite && paddr == OFS_PORT_A && !pslverr
      |-> prdata[23:5] == 19'h7FFFF)
    else $error("unimplemented bits not one");
  po_once_a: assert property (@(posedge clock) disable iff (!rst_n)
    ce && $past(used_r[WI_PORT_B]) && used_r[WI_PORT_B]
      |-> $stable(nvm_r[WI_PORT_B]))
    else $error("programmed word changed");
  pa_map_a: assert property (@(posedge clock) disable iff (!rst_n)
    ce && $past(ce) |-> port_a_pin_owner == $past(nvm_r[WI_PORT_A][4:0]))
    else $error("port a owner mismatch");
  pb_map_a: assert property (@(posedge clock) disable iff (!rst_n)
    ce && $past(ce) |-> port_b_pin_owner == $past(nvm_r[WI_PORT_B][15:0]))
    else $error("port b owner mismatch");
  sel_map_a: assert property (@(posedge clock) disable iff (!rst_n)
    ce && $past(ce) |-> hs_select[15:0] == $past(nvm_r[WI_ASSIGN_LO][15:0]))
    else $error("low selectors mismatch");
  selh_map_a: assert property (@(posedge clock) disable iff (!rst_n)
    ce && $past(ce)
      |-> hs_select[31:16] == $past(nvm_r[WI_ASSIGN_HI][15:0]))
    else $error("high selectors mismatch");
  dir_map_a: assert property (@(posedge clock) disable iff (!rst_n)
    ce && $past(ce) |-> mailbox_direction_fuse == $past(nvm_r[WI_DIR][15:0]))
    else $error("direction mismatch");
endmodule : mhc_cfg

// ---- hw/mhc_pkg.sv ----
package mhc_pkg;
  localparam int unsigned CFG_W      = 24;
  localparam int unsigned NUM_HS     = 8;
  localparam int unsigned NUM_MBX    = 16;
  localparam int unsigned SEL_W      = 4;
  localparam int unsigned PA_PINS    = 5;
  localparam int unsigned PB_PINS    = 16;
  // Word indices of the program-once array
  localparam logic [2:0]  WI_ASSIGN_LO = 3'h0;
  localparam logic [2:0]  WI_ASSIGN_HI = 3'h1;
  localparam logic [2:0]  WI_HS_EN     = 3'h2;
  localparam logic [2:0]  WI_PORT_A    = 3'h3;
  localparam logic [2:0]  WI_PORT_B    = 3'h4;
  localparam logic [2:0]  WI_DIR       = 3'h5;
  localparam int unsigned NUM_WORDS    = 6;
  // APB byte offsets
  localparam logic [7:0]  OFS_ASSIGN_LO = 8'h00;
  localparam logic [7:0]  OFS_ASSIGN_HI = 8'h04;
  localparam logic [7:0]  OFS_HS_EN     = 8'h08;
  localparam logic [7:0]  OFS_PORT_A    = 8'h0C;
  localparam logic [7:0]  OFS_PORT_B    = 8'h10;
  localparam logic [7:0]  OFS_DIR       = 8'h14;
  localparam logic [7:0]  OFS_PROG_KEY  = 8'h18;
  localparam logic [7:0]  OFS_STATUS    = 8'h1C;
  localparam logic [31:0] PROG_KEY_VAL  = 32'h00005A5A;
  // Implemented-bit masks; the rest read as one
  localparam logic [23:0] MASK_16       = 24'h00FFFF;
  localparam logic [23:0] MASK_EN       = 24'h0000FF;
  localparam logic [23:0] MASK_PA       = 24'h00001F;
  localparam logic [23:0] CFG_ERASED    = 24'hFFFFFF;
  localparam int unsigned LOAD_CYCLES   = NUM_WORDS;
endpackage : mhc_pkg

// ---- hw/mhc_hs_flag.sv ----
`timescale 1ns/1ns
module mhc_hs_flag
  import mhc_pkg::*;
(
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic ce,
  input  wire logic active,
  input  wire logic snd_wr,
  input  wire logic rcv_rd,
  output logic      ready_r
);
  logic ready_nxt;

  always_comb begin
    ready_nxt = ready_r;
    if (!active) begin
      ready_nxt = 1'b0;
    end else if (snd_wr) begin
      ready_nxt = 1'b1;
    end else if (rcv_rd) begin
      ready_nxt = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ready_r <= 1'b0;
    end else if (ce) begin
      ready_r <= ready_nxt;
    end
  end
endmodule : mhc_hs_flag

// ---- bench/mhc_partner.sv ----
`timescale 1ns/1ns
module mhc_partner (
  input  wire logic       clock,
  output logic            master_wr,
  output logic            master_rd,
  output logic            slave_wr,
  output logic            slave_rd,
  output logic [3:0]      mbx_index
);
  initial begin
    {master_wr, master_rd, slave_wr, slave_rd} = 4'h0;
    mbx_index = 4'h0;
  end
  // One-cycle pulse; index inverted after so a stale value never helps
  task automatic access(input logic [3:0] kind, input logic [3:0] idx);
    @(posedge clock);
    {master_wr, master_rd, slave_wr, slave_rd} <= kind;
    mbx_index <= idx;
    @(posedge clock);
    {master_wr, master_rd, slave_wr, slave_rd} <= 4'h0;
    mbx_index <= ~idx;
  endtask : access
endmodule : mhc_partner

// ---- bench/tb_top.sv ----
`timescale 1ns/1ns
module tb_top;
  import mhc_pkg::*;
  logic        clock, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic        ce;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, hs_select;
  logic [7:0]  hs_active, hs_ready;
  logic [15:0] dir_fuse, pb_owner;
  logic [4:0]  pa_owner;
  logic        mw, mr, sw, sr;
  logic [3:0]  idx;
  int          mismatches, checks;
  localparam logic [7:0]  OFS [6] = '{OFS_ASSIGN_LO, OFS_ASSIGN_HI,
    OFS_HS_EN, OFS_PORT_A, OFS_PORT_B, OFS_DIR};
  localparam logic [23:0] VAL [6] = '{24'h003210, 24'h00FA50,
    24'h0000F0, 24'h00000A, 24'h005A3C, 24'h00FF00};
  localparam logic [23:0] MSK [6] = '{MASK_16, MASK_16, MASK_EN,
    MASK_PA, MASK_16, MASK_16};

  mhc_cfg dut (.clock(clock), .rst_n(rst_n), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .master_wr(mw), .master_rd(mr), .slave_wr(sw), .slave_rd(sr),
    .mbx_index(idx), .hs_select(hs_select), .hs_active(hs_active),
    .hs_ready(hs_ready), .mailbox_direction_fuse(dir_fuse),
    .port_a_pin_owner(pa_owner), .port_b_pin_owner(pb_owner));
  mhc_partner partner (.clock(clock), .master_wr(mw), .master_rd(mr),
    .slave_wr(sw), .slave_rd(sr), .mbx_index(idx));

  task automatic chk(input string what, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) chk("pready", 32'h1, 32'h0);
  endtask : apb

  task automatic prog(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, OFS_PROG_KEY, PROG_KEY_VAL);
    apb(1'b1, a, d);
  endtask : prog

  task automatic test_defaults;
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, OFS[i], 32'h0);
      chk("erased word", 32'h00FFFFFF, rd);
    end
    chk("select", 32'hFFFFFFFF, hs_select);
    chk("active", 32'h0, {24'h0, hs_active});
    chk("owners", 32'h1FFFFF, {11'h0, pa_owner, pb_owner});
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    apb(1'b1, OFS_PORT_B, 32'h0);
    chk("keyless err", 32'h1, {31'h0, err});
    $display("done defaults");
  endtask : test_defaults

  task automatic test_program;
    for (int i = 0; i < 6; i++) begin
      prog(OFS[i], {8'h00, VAL[i]});
      chk("prog err", 32'h0, {31'h0, err});
      apb(1'b0, OFS[i], 32'h0);
      chk("readback", {8'h00, ~MSK[i] | VAL[i]}, rd);
    end
    chk("select", 32'hFA503210, hs_select);
    chk("active", 32'h0F, {24'h0, hs_active});
    chk("port a", 32'h0A, {27'h0, pa_owner});
    chk("port b", 32'h5A3C, {16'h0, pb_owner});
    chk("direction", 32'hFF00, {16'h0, dir_fuse});
    prog(OFS_ASSIGN_LO, 32'h0);
    chk("second write err", 32'h1, {31'h0, err});
    apb(1'b0, OFS_ASSIGN_LO, 32'h0);
    chk("word kept", 32'h00FF3210, rd);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("status", 32'h0000013F, rd);
    $display("done program");
  endtask : test_program

  // Sender waits for the clear before writing the next word
  task automatic test_handshake;
    partner.access(4'h8, 4'h0);
    #1 chk("ready set", 32'h01, {24'h0, hs_ready});
    partner.access(4'h1, 4'h0);
    #1 chk("ready clear", 32'h0, {24'h0, hs_ready});
    partner.access(4'h2, 4'h1);
    #1 chk("wrong sender", 32'h0, {24'h0, hs_ready});
    partner.access(4'h8, 4'h1);
    #1 chk("ready b", 32'h02, {24'h0, hs_ready});
    // Clock enable low must freeze the flag against a receive
    @(posedge clock) ce <= 1'b0;
    partner.access(4'h1, 4'h1);
    #1 chk("frozen", 32'h02, {24'h0, hs_ready});
    @(posedge clock) ce <= 1'b1;
    partner.access(4'h1, 4'h1);
    #1 chk("ready b clear", 32'h0, {24'h0, hs_ready});
    $display("done handshake");
  endtask : test_handshake

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : conclude

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  initial begin
    #(100 * 3000);
    mismatches++;
    conclude();
  end

  initial begin
    {rst_n, psel, penable, pwrite} = 4'h0;
    ce = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    test_defaults();
    test_program();
    test_handshake();
    conclude();
  end
endmodule : tb_top
